/* sim/ubd_sie_model.sv */
// Behavioural engine model driving the lookup and completion ports
module ubd_sie_model (
    input wire logic clk_i,
    input wire logic done_ready_i,
    output logic lookup_req_o,
    output logic [5:0] lookup_bd_o,
    output logic done_valid_o,
    output logic [5:0] done_bd_o,
    output logic [3:0] done_pid_o,
    output logic [9:0] done_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {lookup_req_o, lookup_bd_o, done_valid_o, done_bd_o,
        done_pid_o, done_count_o} = '0;
    // One request pulse; returns at the edge where the answer stands
    task automatic lookup(input logic [5:0] bd);
        @(posedge clk_i);
        lookup_req_o <= 1'b1;
        lookup_bd_o <= bd;
        @(posedge clk_i);
        lookup_req_o <= 1'b0;
        lookup_bd_o <= ~bd; // Stale index must not look valid
        @(posedge clk_i);
    endtask
    // Record held until accepted, then its fields scrambled
    task automatic complete(input logic [5:0] bd, input logic [3:0] pid,
                            input logic [9:0] cnt);
        @(posedge clk_i);
        done_valid_o <= 1'b1;
        {done_bd_o, done_pid_o, done_count_o} <= {bd, pid, cnt};
        do @(posedge clk_i); while (done_ready_i !== 1'b1);
        done_valid_o <= 1'b0;
        {done_bd_o, done_pid_o, done_count_o} <= ~{bd, pid, cnt};
    endtask
endmodule

/* sim/ubd_table_asserts.sv */
// Port-level checks of the descriptor table block
module ubd_table_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic lookup_req_i,
    input wire logic lookup_valid_o,
    input wire logic [7:0] lookup_status_o,
    input wire logic [9:0] lookup_count_o,
    input wire logic lookup_armed_o,
    input wire logic done_ready_o,
    input wire logic [6:0] device_address_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request waiting for its answer, taken only while running
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // Accepted low-lane write to the device address
    wire addr_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i[13:2] == ubd_pkg::DEV_ADDR_IDX;
    a_ack_answer: assert property (s_req |=> s_ack_pulse)
        else $error("bus answer missing or longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_addr_write: assert property (addr_wr |=>
        device_address_o == $past(wb_dat_i[6:0]))
        else $error("device address not taken from the write");
    a_addr_hold: assert property (!addr_wr |=> $stable(device_address_o))
        else $error("device address moved without a write");
    a_lookup_answer: assert property (lookup_req_i |=> lookup_valid_o)
        else $error("lookup not answered in one cycle");
    a_lookup_cause: assert property (lookup_valid_o |-> $past(lookup_req_i))
        else $error("lookup answer without a request");
    a_lookup_hold: assert property (!lookup_req_i |=> !lookup_valid_o
        && $stable(lookup_status_o) && $stable(lookup_armed_o))
        else $error("lookup result moved without a request");
    a_armed_owned: assert property (lookup_valid_o && lookup_armed_o
        |-> lookup_status_o[ubd_pkg::OWN_BIT])
        else $error("armed descriptor not engine owned");
    a_count_join: assert property (lookup_valid_o
        |-> lookup_count_o[9:8] == lookup_status_o[1:0])
        else $error("count high bits differ from status");
    a_frozen_quiet: assert property (!ce_i |-> !wb_ack_o && !done_ready_o)
        else $error("handshake offered while frozen");
endmodule

bind ubd_table ubd_table_asserts chk_u (.clk_i, .rst_i, .ce_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .lookup_req_i, .lookup_valid_o, .lookup_status_o,
    .lookup_count_o, .lookup_armed_o, .done_ready_o, .device_address_o);

/* sim/ubd_table_tb_top.sv */
// Self-checking bench for the descriptor table block
module ubd_table_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] DEV = ubd_pkg::DEV_ADDR_IDX;
    localparam logic [11:0] CFG = ubd_pkg::CFG_IDX;
    localparam logic [11:0] EPC = ubd_pkg::EP_CTRL_IDX;
    localparam logic [3:0] EXP32 = 4'he;
    localparam logic [3:0] EXP33 = 4'hc;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic [13:0] wb_adr_i = 14'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic [3:0] wb_sel_i = 4'h0, done_pid_i;
    logic lookup_req_i, lookup_valid_o, lookup_armed_o;
    logic done_valid_i, done_ready_o;
    logic [5:0] lookup_bd_i, done_bd_i;
    logic [7:0] lookup_status_o;
    logic [9:0] lookup_count_o, done_count_i;
    logic [15:0] lookup_addr_o;
    logic [6:0] device_address_o;
    int fail_count = 0, num_checks = 0, cycles = 0;
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    ubd_table dut_u (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i,
        .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
        .lookup_req_i, .lookup_bd_i, .lookup_valid_o, .lookup_status_o,
        .lookup_count_o, .lookup_addr_o, .lookup_armed_o, .done_valid_i,
        .done_ready_o, .done_bd_i, .done_pid_i, .done_count_i,
        .device_address_o);
    ubd_sie_model sie_u (.clk_i, .done_ready_i(done_ready_o),
        .lookup_req_o(lookup_req_i), .lookup_bd_o(lookup_bd_i),
        .done_valid_o(done_valid_i), .done_bd_o(done_bd_i),
        .done_pid_o(done_pid_i), .done_count_o(done_count_i));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Single classic cycle; read data taken at the ack edge
    task automatic bus(input logic [11:0] idx, input logic we,
                       input logic [3:0] sel, input logic [7:0] wd);
        @(posedge clk_i);
        wb_adr_i <= {idx, 2'b00};
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, wd};
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
        bus(idx, 1'b1, 4'h1, wd);
    endtask
    // Whole word compared, so upper lanes must read zero
    task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 4'h0, 8'h00);
        check(rdata, {24'h0, exp});
    endtask
    task automatic look(input int bd, input logic [7:0] st, input logic arm);
        sie_u.lookup(6'(bd));
        check(lookup_valid_o, 1'b1);
        check(lookup_status_o, st);
        check(lookup_armed_o, arm);
    endtask
    function automatic logic [11:0] bdx(input int n, input int k);
        return ubd_pkg::TABLE_BASE_IDX + 12'(4 * n + k);
    endfunction
    // Cycle ceiling cuts a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped places and a dropped lane
        rd(DEV, ubd_pkg::DEV_ADDR_RESET);
        rd(CFG, ubd_pkg::CFG_RESET);
        rd(ubd_pkg::TSTAT_IDX, ubd_pkg::TSTAT_RESET);
        rd(ubd_pkg::EP_CTRL_LAST_IDX, ubd_pkg::EP_CTRL_RESET);
        wr(12'h500, 8'h5a);
        rd(12'h500, 8'h00);
        rd(12'h3ff, 8'h00);
        wr(DEV, 8'hff);
        bus(DEV, 1'b1, 4'he, 8'h00);
        rd(DEV, 8'h7f);
        check(device_address_o, 7'h7f);
        check(done_ready_o, 1'b1);
        $display("test registers done");
        // Top descriptor survives a reset in mid-run
        for (int k = 0; k < 4; k++) wr(bdx(63, k), 8'h10 + 8'(k));
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++) rd(bdx(63, k), 8'h10 + 8'(k));
        $display("test table done");
        // Descriptor 5 is endpoint 2 IN in mode 0, endpoint still off
        wr(bdx(5, 1), 8'h40);
        wr(bdx(5, 2), 8'h00);
        wr(bdx(5, 3), 8'h05);
        wr(bdx(5, 0), 8'hc1);
        look(5, 8'hc1, 1'b0);
        check(lookup_count_o, 10'h140);
        check(lookup_addr_o, 16'h0500);
        sie_u.complete(5, 4'h9, 10'h3ff);
        repeat (3) @(posedge clk_i);
        rd(bdx(5, 0), 8'hc1);
        wr(EPC + 12'h2, 8'h02);
        look(5, 8'hc1, 1'b1);
        sie_u.complete(5, 4'hd, 10'h123);
        repeat (3) @(posedge clk_i);
        rd(bdx(5, 0), 8'h75);
        rd(bdx(5, 1), 8'h23);
        rd(ubd_pkg::TSTAT_IDX, 8'h14);
        look(5, 8'h75, 1'b0);
        // Burst through the queue; core-owned records are dropped
        for (int i = 0; i < 20; i++) sie_u.complete(5, 4'h1, 10'h0);
        repeat (3) @(posedge clk_i);
        rd(bdx(5, 0), 8'h75);
        $display("test ownership done");
        // Descriptors 32 and 33 in every buffering mode
        wr(bdx(32, 0), 8'h80);
        wr(bdx(33, 0), 8'h80);
        wr(EPC + 12'h8, 8'h02);
        wr(ubd_pkg::EP_CTRL_LAST_IDX, 8'h02);
        for (int m = 0; m < 4; m++) begin
            wr(CFG, 8'(m));
            rd(CFG, 8'(m));
            look(32, 8'h80, EXP32[m]);
            look(33, 8'h80, EXP33[m]);
        end
        $display("test modes done");
        // Frozen clock enable holds a write back and refuses completions
        ce_i <= 1'b0;
        fork
            wr(DEV, 8'h15);
            begin
                repeat (5) @(posedge clk_i);
                check(device_address_o, 7'h00);
                check(done_ready_o, 1'b0);
                check(wb_ack_o, 1'b0);
                ce_i <= 1'b1;
            end
        join
        rd(DEV, 8'h15);
        check(device_address_o, 7'h15);
        $display("test freeze done");
        conclude();
    end
endmodule

/* src/ubd_pkg.sv */
// Constants and types shared by the descriptor table block
package ubd_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [11:0] TABLE_BASE_IDX = 12'h400;
    localparam logic [11:0] TABLE_LAST_IDX = 12'h4ff;
    localparam logic [11:0] TSTAT_IDX = 12'hf6c;
    localparam logic [11:0] DEV_ADDR_IDX = 12'hf6e;
    localparam logic [11:0] CFG_IDX = 12'hf6f;
    localparam logic [11:0] EP_CTRL_IDX = 12'hf70;
    localparam logic [11:0] EP_CTRL_LAST_IDX = 12'hf7f;

    // Descriptor geometry
    localparam int BD_COUNT = 64;
    localparam int BD_BYTES = 4;
    localparam int TABLE_BYTES = 256;
    localparam logic [1:0] BD_STATUS_OFS = 2'h0;
    localparam logic [1:0] BD_COUNT_OFS = 2'h1;
    localparam logic [1:0] BD_ADDR_LO_OFS = 2'h2;
    localparam logic [1:0] BD_ADDR_HI_OFS = 2'h3;

    // Field positions
    localparam int OWN_BIT = 7;
    localparam int PID_LSB = 2;
    localparam int CNT_HI_LSB = 0;
    localparam int EP_ENABLE_BIT = 1;
    localparam int PPB_LSB = 0;
    localparam logic [7:0] EP_CTRL_WMASK = 8'h1f;
    localparam logic [7:0] DEV_ADDR_WMASK = 8'h7f;

    // Reset values of the control registers
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DEV_ADDR_RESET = 8'h00;
    localparam logic [7:0] TSTAT_RESET = 8'h00;
    localparam logic [7:0] EP_CTRL_RESET = 8'h00;

    // Descriptor sets in use per buffering mode
    localparam logic [6:0] SETS_PLAIN = 7'h20;
    localparam logic [6:0] SETS_EP0_OUT = 7'h21;
    localparam logic [6:0] SETS_ALL = 7'h40;

    // Completion FIFO
    localparam int DONE_WIDTH = 20;
    localparam int DONE_DEPTH = 16;

    typedef enum logic [1:0] {
        UBD_PPB_NONE,
        UBD_PPB_EP0_OUT,
        UBD_PPB_ALL,
        UBD_PPB_ALL_BUT_EP0
    } ubd_ppb_e;
endpackage

/* src/ubd_table.sv */
// Descriptor table with Wishbone slave, engine ports and completion FIFO
//
// Operation
// R1: The table lives in bank 4 and only holds endpoint buffer control.
// R2: Each descriptor is four bytes, with 64 descriptors numbered 0 to 63.
// R3: Descriptor bytes run status, byte count, address low, address high.
// R4: Status byte of descriptor n sits at index 400h plus four times n.
// R5: Descriptors in use are 32, 33 or 64 according to the buffering mode.
// R6: The table spans at least 8 and at most 256 bytes.
// R7: Disabled endpoints' descriptors are plain RAM until enable bit 1 is set.
// R8: Descriptor bytes are not initialised by any reset.
// R9: Software fills a descriptor before enabling its endpoint.
// R10: Status bits mean one thing under core ownership, another under engine.
// R11: Status bit 7 hands the descriptor to the engine when one, core when 0.
// R12: Software leaves an engine-owned descriptor and buffer alone.
// R13: Either party may read a status byte whatever the ownership.
// R14: Software sets status, count and address before handing over.
// R15: The engine writes the token PID into status and updates the count.
// R16: On completion the engine clears ownership, returning it to the core.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.

// Synchronous FIFO with flip-flop storage
module ubd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] fill;
    } ubd_fifo_s;

    ubd_fifo_s state_reg;
    ubd_fifo_s state_next;
    logic push;
    logic pop;

    // Honest flags straight from the fill count
    // Ready falls while frozen, else a pushed record would be lost
    assign in_ready_o = ce_i && state_reg.fill != (AW + 1)'(DEPTH);
    assign out_valid_o = state_reg.fill != '0;
    assign out_data_o = state_reg.mem[state_reg.rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and storage update
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = in_data_i;
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10: state_next.fill = state_reg.fill + 1'b1;
            2'b01: state_next.fill = state_reg.fill - 1'b1;
            default: state_next.fill = state_reg.fill;
        endcase
    end

    // Storage keeps its contents over reset, pointers do not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.wr_ptr <= '0;
            state_reg.rd_ptr <= '0;
            state_reg.fill <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end
endmodule

// Descriptor table top
module ubd_table (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic lookup_req_i,
    input wire logic [5:0] lookup_bd_i,
    output logic lookup_valid_o,
    output logic [7:0] lookup_status_o,
    output logic [9:0] lookup_count_o,
    output logic [15:0] lookup_addr_o,
    output logic lookup_armed_o,
    input wire logic done_valid_i,
    output logic done_ready_o,
    input wire logic [5:0] done_bd_i,
    input wire logic [3:0] done_pid_i,
    input wire logic [9:0] done_count_i,
    output logic [6:0] device_address_o
);
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic lk_valid;
        logic [7:0] lk_status;
        logic [9:0] lk_count;
        logic [15:0] lk_addr;
        logic lk_armed;
        logic [7:0] cfg;
        logic [7:0] dev_addr;
        logic [7:0] tstat;
        logic [15:0][7:0] ep_ctrl;
        logic [ubd_pkg::TABLE_BYTES-1:0][7:0] table_mem;
    } ubd_state_s;

    // Register kinds that a bus index can reach
    typedef enum logic [2:0] {
        UBD_SEL_NONE,
        UBD_SEL_TABLE,
        UBD_SEL_EP_CTRL,
        UBD_SEL_CFG,
        UBD_SEL_DEV_ADDR,
        UBD_SEL_TSTAT
    } ubd_sel_e;

    ubd_state_s state_reg;
    ubd_state_s state_next;
    ubd_sel_e sel;
    logic [11:0] idx;
    logic bus_take;
    logic dn_take;
    logic bus_req;
    logic bus_wr;
    logic [5:0] lk_map;
    logic [5:0] dn_map;
    logic lk_in_use;
    logic dn_in_use;
    logic lk_enabled;
    logic dn_enabled;
    logic fifo_valid;
    logic fifo_ready;
    logic [ubd_pkg::DONE_WIDTH-1:0] fifo_data;
    logic [5:0] dn_bd;
    logic [3:0] dn_pid;
    logic [9:0] dn_count;
    logic [7:0] dn_status;

    // Descriptor number to {endpoint, dir, odd}, per buffering mode
    function automatic logic [5:0] bd_map(input logic [5:0] bd,
                                          input logic [1:0] mode);
        logic [5:0] m;
        m = bd - 6'h01;
        case (ubd_pkg::ubd_ppb_e'(mode))
            ubd_pkg::UBD_PPB_NONE: bd_map = {bd[4:1], bd[0], 1'b0};
            ubd_pkg::UBD_PPB_EP0_OUT: begin
                if (bd < 6'h02) begin
                    bd_map = {4'h0, 1'b0, bd[0]};
                end else begin
                    bd_map = {m[4:1], m[0], 1'b0};
                end
            end
            default: bd_map = {bd[5:2], bd[1], bd[0]};
        endcase
    endfunction

    // Whether a descriptor number is inside the sets of the mode
    function automatic logic bd_in_use(input logic [5:0] bd,
                                       input logic [1:0] mode);
        logic [6:0] limit;
        case (ubd_pkg::ubd_ppb_e'(mode))
            ubd_pkg::UBD_PPB_NONE: limit = ubd_pkg::SETS_PLAIN;
            ubd_pkg::UBD_PPB_EP0_OUT: limit = ubd_pkg::SETS_EP0_OUT;
            default: limit = ubd_pkg::SETS_ALL;
        endcase
        bd_in_use = {1'b0, bd} < limit; // R5
    endfunction

    // Byte position of a descriptor field in the table
    function automatic logic [7:0] bd_byte(input logic [5:0] bd,
                                           input logic [1:0] ofs);
        bd_byte = {bd, ofs}; // R2 R3 R4
    endfunction

    // Which register a bus index reaches, for reads and writes alike
    function automatic ubd_sel_e reg_sel(input logic [11:0] i);
        // Table and endpoint controls are ranges, the rest single places
        reg_sel = UBD_SEL_NONE;
        if (i >= ubd_pkg::TABLE_BASE_IDX &&
            i <= ubd_pkg::TABLE_LAST_IDX) begin
            reg_sel = UBD_SEL_TABLE;
        end else if (i >= ubd_pkg::EP_CTRL_IDX &&
                     i <= ubd_pkg::EP_CTRL_LAST_IDX) begin
            reg_sel = UBD_SEL_EP_CTRL;
        end else if (i == ubd_pkg::CFG_IDX) begin
            reg_sel = UBD_SEL_CFG;
        end else if (i == ubd_pkg::DEV_ADDR_IDX) begin
            reg_sel = UBD_SEL_DEV_ADDR;
        end else if (i == ubd_pkg::TSTAT_IDX) begin
            reg_sel = UBD_SEL_TSTAT;
        end
    endfunction

    assign idx = wb_adr_i[13:2];
    // Index decode shared by the read and write paths
    assign sel = reg_sel(idx);
    assign bus_req = wb_cyc_i && wb_stb_i;
    // A request is taken once; the ack cycle does not re-take it
    assign bus_take = bus_req && !state_reg.ack;
    // Write lands at the edge where the master sees ack
    assign bus_wr = bus_req && state_reg.ack && wb_we_i && wb_sel_i[0];

    assign lk_map = bd_map(lookup_bd_i, state_reg.cfg[1:0]);
    assign lk_in_use = bd_in_use(lookup_bd_i, state_reg.cfg[1:0]);
    assign lk_enabled =
        state_reg.ep_ctrl[lk_map[5:2]][ubd_pkg::EP_ENABLE_BIT]; // R7

    assign {dn_bd, dn_pid, dn_count} = fifo_data;
    assign dn_map = bd_map(dn_bd, state_reg.cfg[1:0]);
    assign dn_in_use = bd_in_use(dn_bd, state_reg.cfg[1:0]);
    assign dn_enabled =
        state_reg.ep_ctrl[dn_map[5:2]][ubd_pkg::EP_ENABLE_BIT]; // R7
    assign dn_status = state_reg.table_mem[
        bd_byte(dn_bd, ubd_pkg::BD_STATUS_OFS)];

    // Completion acts only on an enabled, in-use, engine-owned entry
    assign dn_take = fifo_valid && fifo_ready && dn_in_use && dn_enabled &&
        dn_status[ubd_pkg::OWN_BIT]; // R11 R7 R5

    // Bus writes win the table port; completions wait a cycle
    assign fifo_ready = !bus_wr;

    // Completion records queue here so the engine sees back-pressure
    ubd_fifo #(
        .WIDTH(ubd_pkg::DONE_WIDTH),
        .DEPTH(ubd_pkg::DONE_DEPTH)
    ) u_done_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(done_valid_i),
        .in_ready_o(done_ready_o),
        .in_data_i({done_bd_i, done_pid_i, done_count_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_data)
    );

    // Next state: bus slave, engine lookup, completion write-back
    always_comb begin
        state_next = state_reg;
        state_next.lk_valid = 1'b0;

        // Single-wait-state ack, dropped the cycle after it is given
        state_next.ack = bus_take;
        if (bus_take) begin
            state_next.rdata = 8'h00;
            case (sel)
                UBD_SEL_TABLE: begin
                    // Always readable, owned or not, enabled or not
                    state_next.rdata = state_reg.table_mem[idx[7:0]]; // R13 R7
                end
                UBD_SEL_EP_CTRL: begin
                    state_next.rdata = state_reg.ep_ctrl[idx[3:0]];
                end
                UBD_SEL_CFG: state_next.rdata = state_reg.cfg;
                UBD_SEL_DEV_ADDR: state_next.rdata = state_reg.dev_addr;
                UBD_SEL_TSTAT: state_next.rdata = state_reg.tstat;
                default: state_next.rdata = 8'h00;
            endcase
        end

        // Software writes; unmapped indices are acked and dropped
        if (bus_wr) begin
            case (sel)
                UBD_SEL_TABLE: begin
                    // No ownership guard: software must respect the flag
                    state_next.table_mem[idx[7:0]] = wb_dat_i[7:0]; // R1 R6
                end
                UBD_SEL_EP_CTRL: begin
                    state_next.ep_ctrl[idx[3:0]] =
                        wb_dat_i[7:0] & ubd_pkg::EP_CTRL_WMASK;
                end
                UBD_SEL_CFG: state_next.cfg = wb_dat_i[7:0];
                UBD_SEL_DEV_ADDR: begin
                    state_next.dev_addr =
                        wb_dat_i[7:0] & ubd_pkg::DEV_ADDR_WMASK;
                end
                default: begin
                    // Read-only status and unmapped places drop the write
                end
            endcase
        end

        // Engine lookup, answered one cycle later from flip-flops
        if (lookup_req_i) begin
            state_next.lk_valid = 1'b1;
            state_next.lk_status = state_reg.table_mem[
                bd_byte(lookup_bd_i, ubd_pkg::BD_STATUS_OFS)]; // R13
            state_next.lk_count = {
                state_next.lk_status[ubd_pkg::CNT_HI_LSB +: 2],
                state_reg.table_mem[
                    bd_byte(lookup_bd_i, ubd_pkg::BD_COUNT_OFS)]};
            state_next.lk_addr = {
                state_reg.table_mem[
                    bd_byte(lookup_bd_i, ubd_pkg::BD_ADDR_HI_OFS)],
                state_reg.table_mem[
                    bd_byte(lookup_bd_i, ubd_pkg::BD_ADDR_LO_OFS)]};
            // Only enabled, in-use, engine-owned entries count
            state_next.lk_armed = lk_in_use && lk_enabled &&
                state_next.lk_status[ubd_pkg::OWN_BIT]; // R11 R7 R5
        end

        // Completion: engine layout of status, ownership back to core
        if (dn_take) begin
            state_next.table_mem[
                bd_byte(dn_bd, ubd_pkg::BD_STATUS_OFS)] = {
                1'b0, // R16
                dn_status[6],
                dn_pid, // R15 R10
                dn_count[9:8]};
            state_next.table_mem[
                bd_byte(dn_bd, ubd_pkg::BD_COUNT_OFS)] = dn_count[7:0]; // R15
            // Last completion: endpoint, direction and odd slot
            state_next.tstat = {1'b0, dn_map, 1'b0};
        end
    end

    // Control state resets; descriptor bytes are left as they were
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.ack <= 1'b0;
            state_reg.rdata <= 8'h00;
            state_reg.lk_valid <= 1'b0;
            state_reg.lk_status <= 8'h00;
            state_reg.lk_count <= 10'h000;
            state_reg.lk_addr <= 16'h0000;
            state_reg.lk_armed <= 1'b0;
            state_reg.cfg <= ubd_pkg::CFG_RESET;
            state_reg.dev_addr <= ubd_pkg::DEV_ADDR_RESET;
            state_reg.tstat <= ubd_pkg::TSTAT_RESET;
            state_reg.ep_ctrl <= {16{ubd_pkg::EP_CTRL_RESET}}; // R8
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // Handshakes masked while frozen: a held ack would let the master
    // leave before the write lands, a held valid would count twice
    assign wb_ack_o = state_reg.ack && ce_i;
    assign lookup_valid_o = state_reg.lk_valid && ce_i;

    // Data outputs straight from state
    assign wb_dat_o = {24'h000000, state_reg.rdata};
    assign lookup_status_o = state_reg.lk_status;
    assign lookup_count_o = state_reg.lk_count;
    assign lookup_addr_o = state_reg.lk_addr;
    assign lookup_armed_o = state_reg.lk_armed;
    assign device_address_o = state_reg.dev_addr[6:0];
endmodule
